// ===== hdl/tmc_counter.sv
/*
 * 16-bit up/down timer register with reload and wrap handling.
 * Assumes the caller decodes mode into tick, direction and loads.
 */
`timescale 1ns/1ps
`include "tmc_params.svh"

module tmc_counter (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic up_in,
  input wire logic auto_in,
  input wire logic [15:0] bottom_in,
  input wire logic ext_load_in,
  input wire logic sw_we_in,
  input wire logic [15:0] sw_val_in,
  output logic [15:0] count_out,
  output logic roll_out
);

  logic [15:0] next_count;

  ////////////////////////////////////////////////////////////////////
  // down count rolls at the reload value, up count at the top
  always_comb begin
    roll_out = tick_in & (up_in ? (count_out == `TMC_COUNT_MAX)
                                : (count_out == bottom_in));
    next_count = count_out;
    if (sw_we_in) begin
      next_count = sw_val_in;
    end else if (ext_load_in) begin
      next_count = bottom_in;
    end else if (tick_in) begin
      if (roll_out) begin
        next_count = !up_in ? `TMC_COUNT_MAX :
                     (auto_in ? bottom_in : `TMC_COUNT_RESET);
      end else if (up_in) begin
        next_count = count_out + 16'h0001;
      end else begin
        next_count = count_out - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_out <= `TMC_COUNT_RESET;
    end else begin
      count_out <= next_count;
    end
  end

endmodule : tmc_counter

// ===== hdl/tmc_params.svh
/*
 * Offsets, field positions, reset values and widths for the timer
 * mode control block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// register indices; byte address is four times the index
`define TMC_IDX_CTRL 8'hC8
`define TMC_IDX_MODE 8'hC9
`define TMC_IDX_RELOAD 8'hCA
`define TMC_IDX_CAPTURE 8'hCB
`define TMC_IDX_COUNT 8'hCC
`define TMC_IDX_IRQ_STATUS 8'hCD
`define TMC_IDX_IRQ_MASK 8'hCE

`define TMC_AW 10
`define TMC_ADDR(idx) ({(idx), 2'b00})

`define TMC_CTRL_RESET 8'h00
`define TMC_MODE_RESET 8'h00
`define TMC_RELOAD_RESET 16'h0000
`define TMC_COUNT_RESET 16'h0000
`define TMC_COUNT_MAX 16'hFFFF
`define TMC_PIN_IDLE 1'b1

// interrupt status and mask layout
`define TMC_IRQ_OVF 0
`define TMC_IRQ_EXT 1
`define TMC_IRQ_W 2

`endif

// ===== hdl/tmc_pin_sync.sv
/*
 * Three-stage pin synchroniser with a debounced level and a
 * falling-edge pulse.
 * Assumes the pin is asynchronous to clk_in; idles high.
 */
`timescale 1ns/1ps
`include "tmc_params.svh"

module tmc_pin_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out,
  output logic fall_out
);

  logic s1, s2, s3;
  logic next_level;

  ////////////////////////////////////////////////////////////////////
  // a change counts only once the last two stages agree
  always_comb begin
    next_level = (s2 == s3) ? s3 : level_out;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1 <= `TMC_PIN_IDLE;
      s2 <= `TMC_PIN_IDLE;
      s3 <= `TMC_PIN_IDLE;
      level_out <= `TMC_PIN_IDLE;
      fall_out <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      level_out <= next_level;
      fall_out <= level_out & ~next_level;
    end
  end

  ////////////////////////////////////////////////////////////////////
  AST_FALL_EDGE: assert property (@(posedge clk_in) disable iff (rst_in)
    fall_out |-> !level_out && $past(level_out))
    else $error("falling edge pulse without a high-to-low level");

endmodule : tmc_pin_sync

// ===== hdl/tmc_pkg.sv
/*
 * Types shared by the timer mode control block.
 * Assumes tmc_params.svh supplies the numeric constants.
 */
package tmc_pkg;

  typedef struct packed {
    logic overflow_flag;
    logic ext_flag;
    logic rx_baud_select;
    logic tx_baud_select;
    logic ext_pin_enable;
    logic run_bit;
    logic count_source_select;
    logic capture_reload_select;
  } tmc_ctrl_type;

  typedef struct packed {
    logic [5:0] unused_bits;
    logic clock_out_enable;
    logic down_count_enable;
  } tmc_mode_type;

endpackage : tmc_pkg

// ===== hdl/tmc_top.sv
/*
 * Mode control for a 16-bit general timer: run control, source
 * select, capture/reload, baud and clock-out priority, up/down,
 * with an Avalon-MM register slave and one interrupt line.
 * Assumes pins are asynchronous; other_timer_ovf_in is a one-cycle
 * pulse on clk_in.
 */
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "tmc_params.svh"

// What this block does
// - count pin falls or internal ticks, by select
// - trigger fall captures count when capture enabled
// - reload on overflow unless capturing (then wrap to 0), or enabled trigger fall
// - baud select forces auto-reload, ignores capture
// - baud and clock-out outrank capture select
// - clock-out toggles count pin on overflow
// - down enable lets trigger level set direction
// - mode register resets to zero
// - run bit starts and stops counting
// - external flag set by trigger capture/reload
// - receive baud takes this or other overflow
module tmc_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [`TMC_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic count_clock_pin_in,
  output logic count_clock_pin_out,
  output logic count_clock_pin_oe_out,
  input wire logic ext_trigger_pin_in,
  input wire logic other_timer_ovf_in,
  output logic rx_baud_clk_out,
  output logic tx_baud_clk_out,
  output logic irq_out
);

  tmc_pkg::tmc_ctrl_type ctrl, next_ctrl;
  tmc_pkg::tmc_mode_type mode, next_mode;
  logic [15:0] reload, next_reload;
  logic [15:0] capture, next_capture;
  logic [`TMC_IRQ_W-1:0] irq_st, next_irq_st;
  logic [`TMC_IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_readdata, rdata;
  logic next_wait, next_pin, next_oe, next_rx, next_tx, next_irq;
  logic cnt_fall, trig_fall, trig_level;
  logic [15:0] count;
  logic roll;
  logic baud, clkout, capture_mode, updown, count_up, tick;
  logic trig_ev, ext_load, cap_ev, ovf_set, ext_set, ext_toggle;
  logic wr, sw_cnt_we;
  logic [`TMC_IRQ_W-1:0] irq_ev;

  ////////////////////////////////////////////////////////////////////
  // pin front ends

  tmc_pin_sync u_count_pin (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(count_clock_pin_in),
    .level_out(),
    .fall_out(cnt_fall)
  );

  tmc_pin_sync u_trig_pin (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(ext_trigger_pin_in),
    .level_out(trig_level),
    .fall_out(trig_fall)
  );

  ////////////////////////////////////////////////////////////////////
  // mode decode

  always_comb begin
    baud = ctrl.rx_baud_select | ctrl.tx_baud_select;
    // own output toggles must not be counted, hence source select 0
    clkout = mode.clock_out_enable & ~ctrl.count_source_select;
    capture_mode = ctrl.capture_reload_select & ~baud
                   & ~mode.clock_out_enable;
    updown = ~capture_mode & ~baud & mode.down_count_enable
             & ctrl.ext_pin_enable;
    count_up = ~updown | trig_level;
    tick = ctrl.run_bit
           & (ctrl.count_source_select ? cnt_fall : 1'b1);
    trig_ev = trig_fall & ctrl.ext_pin_enable;
    cap_ev = trig_ev & capture_mode;
    // trigger in baud mode only flags, it never reloads
    ext_load = trig_ev & ~capture_mode & ~baud & ~updown;
    ext_set = cap_ev | ext_load | (trig_ev & baud);
    ext_toggle = updown & roll;
    ovf_set = roll & ~baud & ~mode.clock_out_enable;
  end

  ////////////////////////////////////////////////////////////////////
  // timer register

  tmc_counter u_counter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(tick),
    .up_in(count_up),
    .auto_in(~capture_mode),
    .bottom_in(reload),
    .ext_load_in(ext_load),
    .sw_we_in(sw_cnt_we),
    .sw_val_in(avs_writedata_in[15:0]),
    .count_out(count),
    .roll_out(roll)
  );

  ////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, transfer on the edge with wait low

  always_comb begin
    wr = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
    sw_cnt_we = wr
                & (avs_address_in == `TMC_ADDR(`TMC_IDX_COUNT));
    next_wait = ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
    unique case (avs_address_in)
      `TMC_ADDR(`TMC_IDX_CTRL): rdata = {24'h000000, ctrl};
      `TMC_ADDR(`TMC_IDX_MODE): rdata = {24'h000000, mode};
      `TMC_ADDR(`TMC_IDX_RELOAD): rdata = {16'h0000, reload};
      `TMC_ADDR(`TMC_IDX_CAPTURE): rdata = {16'h0000, capture};
      `TMC_ADDR(`TMC_IDX_COUNT): rdata = {16'h0000, count};
      `TMC_ADDR(`TMC_IDX_IRQ_STATUS): rdata = {30'h00000000, irq_st};
      `TMC_ADDR(`TMC_IDX_IRQ_MASK): rdata = {30'h00000000, irq_mask};
      default: rdata = 32'h00000000;
    endcase
    next_readdata = (avs_read_in & avs_waitrequest_out) ? rdata
                                                        : avs_readdata_out;
  end

  ////////////////////////////////////////////////////////////////////
  // control, mode, reload and capture registers

  always_comb begin
    next_ctrl = ctrl;
    next_mode = mode;
    next_reload = reload;
    next_capture = capture;
    if (wr && avs_address_in == `TMC_ADDR(`TMC_IDX_CTRL)) begin
      next_ctrl = avs_writedata_in[7:0];
    end
    if (wr && avs_address_in == `TMC_ADDR(`TMC_IDX_MODE)) begin
      next_mode = avs_writedata_in[7:0];
      next_mode.unused_bits = 6'h00;
    end
    if (wr && avs_address_in == `TMC_ADDR(`TMC_IDX_RELOAD)) begin
      next_reload = avs_writedata_in[15:0];
    end
    // hardware set wins over a software clear in the same cycle
    if (ovf_set) begin
      next_ctrl.overflow_flag = 1'b1;
    end
    if (ext_set) begin
      next_ctrl.ext_flag = 1'b1;
    end else if (ext_toggle) begin
      next_ctrl.ext_flag = ~ctrl.ext_flag;
    end
    if (cap_ev) begin
      next_capture = count;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write one to clear, mask gates

  always_comb begin
    irq_ev = '0;
    irq_ev[`TMC_IRQ_OVF] = ovf_set;
    // up/down mode uses the external flag as a 17th bit, no event
    irq_ev[`TMC_IRQ_EXT] = ext_set;
    next_irq_st = irq_st;
    next_irq_mask = irq_mask;
    if (wr && avs_address_in == `TMC_ADDR(`TMC_IDX_IRQ_STATUS)) begin
      next_irq_st = irq_st & ~avs_writedata_in[`TMC_IRQ_W-1:0];
    end
    if (wr && avs_address_in == `TMC_ADDR(`TMC_IDX_IRQ_MASK)) begin
      next_irq_mask = avs_writedata_in[`TMC_IRQ_W-1:0];
    end
    next_irq_st = next_irq_st | irq_ev;
    next_irq = |(next_irq_st & next_irq_mask);
  end

  ////////////////////////////////////////////////////////////////////
  // pin and baud clock outputs

  always_comb begin
    next_oe = clkout;
    next_pin = (clkout & roll) ? ~count_clock_pin_out
                               : count_clock_pin_out;
    next_rx = ctrl.rx_baud_select ? roll : other_timer_ovf_in;
    next_tx = ctrl.tx_baud_select ? roll : other_timer_ovf_in;
  end

  ////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl <= `TMC_CTRL_RESET;
      mode <= `TMC_MODE_RESET;
      reload <= `TMC_RELOAD_RESET;
      capture <= `TMC_RELOAD_RESET;
      irq_st <= '0;
      irq_mask <= '0;
      irq_out <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
      count_clock_pin_out <= `TMC_PIN_IDLE;
      count_clock_pin_oe_out <= 1'b0;
      rx_baud_clk_out <= 1'b0;
      tx_baud_clk_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      mode <= next_mode;
      reload <= next_reload;
      capture <= next_capture;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      irq_out <= next_irq;
      avs_waitrequest_out <= next_wait;
      avs_readdata_out <= next_readdata;
      count_clock_pin_out <= next_pin;
      count_clock_pin_oe_out <= next_oe;
      rx_baud_clk_out <= next_rx;
      tx_baud_clk_out <= next_tx;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  AST_SRC_PIN: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl.run_bit && ctrl.count_source_select && !cnt_fall
    && !sw_cnt_we && !ext_load |=> count == $past(count))
    else $error("counter moved without a count pin fall");

  AST_CAPTURE: assert property (@(posedge clk_in) disable iff (rst_in)
    cap_ev |=> capture == $past(count))
    else $error("capture did not take the timer value");

  AST_EXT_RELOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    ext_load && !sw_cnt_we |=> count == $past(reload))
    else $error("trigger fall did not reload the timer");

  AST_BAUD_RELOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    baud && roll && !sw_cnt_we |=> count == $past(reload) && !ctrl.overflow_flag
    || $past(ctrl.overflow_flag))
    else $error("baud mode overflow did not auto-reload");

  AST_CLKOUT_PRIO: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl.capture_reload_select && mode.clock_out_enable && tick && count_up
    && count == `TMC_COUNT_MAX && !sw_cnt_we |=> count == $past(reload))
    else $error("clock-out did not take priority over capture");

  AST_CLKOUT: assert property (@(posedge clk_in) disable iff (rst_in)
    clkout && roll |=> count_clock_pin_out != $past(count_clock_pin_out)
    && count_clock_pin_oe_out)
    else $error("count pin did not toggle on overflow");

  AST_DOWN: assert property (@(posedge clk_in) disable iff (rst_in)
    updown && !trig_level && tick && count != reload && !sw_cnt_we
    |=> count == $past(count) - 16'h0001)
    else $error("timer did not count down with trigger low");

  AST_MODE_RESET: assert property (@(posedge clk_in) disable iff (1'b0)
    $past(rst_in) && !rst_in |-> mode == `TMC_MODE_RESET && !count_clock_pin_oe_out)
    else $error("mode register not zero after reset");

  AST_RUN_STOP: assert property (@(posedge clk_in) disable iff (rst_in)
    (!ctrl.run_bit && !sw_cnt_we && !ext_load) [*2] |-> count == $past(count))
    else $error("timer counted while stopped");

  AST_EXT_FLAG: assert property (@(posedge clk_in) disable iff (rst_in)
    cap_ev || ext_load |=> ctrl.ext_flag && irq_st[`TMC_IRQ_EXT])
    else $error("external flag not set by trigger event");

  AST_RX_CLK: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl.rx_baud_select && roll |=> rx_baud_clk_out)
    else $error("receive baud clock missed a timer overflow");

  AST_TX_CLK: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl.tx_baud_select && roll |=> tx_baud_clk_out)
    else $error("transmit baud clock missed a timer overflow");

  AST_INT_TICK: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl.run_bit && !ctrl.count_source_select && count_up && !roll
    && !sw_cnt_we && !ext_load |=> count == $past(count) + 16'h0001)
    else $error("timer missed an internal tick");

  AST_OVF_RELOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    roll && count_up && !capture_mode && !sw_cnt_we |=> count == $past(reload))
    else $error("overflow did not reload the timer");

  AST_OVF_FLAG: assert property (@(posedge clk_in) disable iff (rst_in)
    ovf_set |=> ctrl.overflow_flag && irq_st[`TMC_IRQ_OVF])
    else $error("overflow flag not set on timer overflow");

endmodule : tmc_top

// ===== tb/tb_top.sv
/*
 * Self-checking bench for the timer mode control block.
 * Assumes the Avalon slave ends each transfer with waitrequest low;
 * the master waits for it, bounded by its own timeout.
 */
`timescale 1ns/1ps
`include "tmc_params.svh"

module tb_top;
  localparam logic [9:0] A_CTRL = `TMC_ADDR(`TMC_IDX_CTRL);
  localparam logic [9:0] A_MODE = `TMC_ADDR(`TMC_IDX_MODE);
  localparam logic [9:0] A_REL = `TMC_ADDR(`TMC_IDX_RELOAD);
  localparam logic [9:0] A_CAP = `TMC_ADDR(`TMC_IDX_CAPTURE);
  localparam logic [9:0] A_CNT = `TMC_ADDR(`TMC_IDX_COUNT);
  localparam logic [9:0] A_STS = `TMC_ADDR(`TMC_IDX_IRQ_STATUS);
  localparam logic [9:0] A_MSK = `TMC_ADDR(`TMC_IDX_IRQ_MASK);

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] avs_address_in = 10'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [3:0] be_mask = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic count_pin;
  logic count_clock_pin_out;
  logic count_clock_pin_oe_out;
  logic trig_pin;
  logic other_timer_ovf_in = 1'b0;
  logic rx_baud_clk_out;
  logic tx_baud_clk_out;
  logic irq_out;
  int fail_count = 0;
  int compares = 0;
  int tx_n = 0;
  int rx_n = 0;
  int tog = 0;
  logic last_po = 1'b1;

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  tmc_top dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .count_clock_pin_in(count_pin), .count_clock_pin_out(count_clock_pin_out),
    .count_clock_pin_oe_out(count_clock_pin_oe_out), .ext_trigger_pin_in(trig_pin),
    .other_timer_ovf_in(other_timer_ovf_in), .rx_baud_clk_out(rx_baud_clk_out),
    .tx_baud_clk_out(tx_baud_clk_out), .irq_out(irq_out));

  tmc_pin_model pm (.clk_in(clk_in), .drive_in(count_clock_pin_out),
    .drive_oe_in(count_clock_pin_oe_out), .count_pin_out(count_pin),
    .trig_pin_out(trig_pin));

  always @(posedge clk_in) begin
    if (tx_baud_clk_out === 1'b1) tx_n++;
    if (rx_baud_clk_out === 1'b1) rx_n++;
    if (count_clock_pin_out !== last_po) tog++;
    last_po = count_clock_pin_out;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // request held until a rising edge samples waitrequest low; read
  // data is taken at that same edge, before the slave's update
  task automatic bus(input logic wr, input logic [9:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    logic fin;
    n = 0;
    fin = 1'b0;
    r = 32'h0;
    @(posedge clk_in);
    avs_address_in <= ad;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= d;
    avs_byteenable_in <= be_mask;
    while (!fin) begin
      @(posedge clk_in);
      fin = (avs_waitrequest_out === 1'b0);
      r = avs_readdata_out;
      n++;
      if (n > 20) begin
        fail_count++;
        complete_run();
      end
    end
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] ad, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, ad, d, r);
  endtask : wr

  task automatic rd(input logic [9:0] ad, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, ad, 32'h0, r);
    chk(r, e);
  endtask : rd

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(A_MODE, 32'h0);
    rd(A_CTRL, 32'h0);
    rd(10'h3FC, 32'h0);
    // a write without byte lane 0 must leave the mode register alone
    be_mask = 4'hE;
    wr(A_MODE, 32'h3);
    be_mask = 4'hF;
    rd(A_MODE, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_run;
    wr(A_CNT, 32'h0);
    wr(A_CTRL, 32'h04);
    repeat (10) @(posedge clk_in);
    // ten idle edges plus three edges of the stop write, one wait cycle
    wr(A_CTRL, 32'h0);
    rd(A_CNT, 32'hD);
    repeat (5) @(posedge clk_in);
    rd(A_CNT, 32'hD);
    wr(A_CNT, 32'h0);
    wr(A_CTRL, 32'h06);
    repeat (5) pm.fall_count();
    rd(A_CNT, 32'h5);
    $display("test run done");
  endtask : t_run

  task automatic t_capture;
    wr(A_CTRL, 32'h0);
    wr(A_CNT, 32'h1234);
    wr(A_CTRL, 32'h09);
    pm.fall_trig();
    rd(A_CAP, 32'h1234);
    rd(A_CTRL, 32'h49);
    chk({31'h0, irq_out}, 32'h0);
    wr(A_MSK, 32'h2);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    wr(A_STS, 32'h2);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    rd(A_STS, 32'h0);
    $display("test capture done");
  endtask : t_capture

  task automatic t_reload;
    wr(A_CTRL, 32'h0);
    wr(A_REL, 32'h0100);
    wr(A_CNT, 32'h0050);
    wr(A_CTRL, 32'h08);
    pm.fall_trig();
    rd(A_CNT, 32'h0100);
    wr(A_CNT, 32'hFFFF);
    wr(A_CTRL, 32'h06);
    pm.fall_count();
    rd(A_CNT, 32'h0100);
    rd(A_CTRL, 32'h86);
    rd(A_STS, 32'h3);
    wr(A_STS, 32'h3);
    $display("test reload done");
  endtask : t_reload

  task automatic t_baud;
    int n0;
    wr(A_CTRL, 32'h0);
    wr(A_REL, 32'h0200);
    wr(A_CNT, 32'hFFFF);
    n0 = tx_n;
    wr(A_CTRL, 32'h1F);
    pm.fall_count();
    rd(A_CNT, 32'h0200);
    rd(A_CTRL, 32'h1F);
    chk(32'(tx_n - n0), 32'h1);
    wr(A_CTRL, 32'h1B);
    wr(A_CNT, 32'h0005);
    pm.fall_trig();
    rd(A_CNT, 32'h0005);
    rd(A_CTRL, 32'h5B);
    wr(A_CTRL, 32'h0);
    n0 = rx_n;
    @(posedge clk_in);
    other_timer_ovf_in <= 1'b1;
    @(posedge clk_in);
    other_timer_ovf_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(32'(rx_n - n0), 32'h1);
    wr(A_CNT, 32'hFFFF);
    n0 = rx_n;
    wr(A_CTRL, 32'h26);
    pm.fall_count();
    chk(32'(rx_n - n0), 32'h1);
    wr(A_CTRL, 32'h0);
    $display("test baud done");
  endtask : t_baud

  task automatic t_clkout;
    int t0;
    wr(A_REL, 32'hFFF0);
    wr(A_CNT, 32'hFFF0);
    wr(A_MODE, 32'h2);
    rd(A_MODE, 32'h2);
    t0 = tog;
    // source select kept 0 while clock-out is used; capture select set
    // too, so a wrong capture decode would stop the 16-cycle toggling
    wr(A_CTRL, 32'h05);
    repeat (100) @(posedge clk_in);
    chk({31'h0, count_clock_pin_oe_out}, 32'h1);
    chk(32'(tog - t0), 32'h6);
    wr(A_CTRL, 32'h0);
    wr(A_MODE, 32'h0);
    $display("test clock-out done");
  endtask : t_clkout

  task automatic t_updown;
    pm.set_trig(1'b0);
    wr(A_MODE, 32'h1);
    wr(A_REL, 32'h0);
    wr(A_CNT, 32'h0010);
    wr(A_CTRL, 32'h0E);
    pm.fall_count();
    rd(A_CNT, 32'h000F);
    pm.set_trig(1'b1);
    pm.fall_count();
    rd(A_CNT, 32'h0010);
    wr(A_CTRL, 32'h0);
    wr(A_MODE, 32'h0);
    $display("test up-down done");
  endtask : t_updown

  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_run();
    t_capture();
    t_reload();
    t_baud();
    t_clkout();
    t_updown();
    complete_run();
  end
endmodule : tb_top

// ===== tb/tmc_pin_model.sv
/*
 * Model of the external sources on the count clock pin and the
 * external trigger pin.
 * Assumes the bench calls its tasks; while clock-out drives the count
 * pin, the pin shows the block's own output.
 */
`timescale 1ns/1ps

module tmc_pin_model (
  input wire logic clk_in,
  input wire logic drive_in,
  input wire logic drive_oe_in,
  output logic count_pin_out,
  output logic trig_pin_out
);
  logic cnt_lvl;
  logic trig_lvl;

  initial begin
    cnt_lvl = 1'b1;
    trig_lvl = 1'b1;
  end

  // pulled high when nobody drives it
  assign count_pin_out = drive_oe_in ? drive_in : cnt_lvl;
  assign trig_pin_out = trig_lvl;

  ////////////////////////////////////////////////////////////////////
  // each level held well beyond the three-sample synchroniser
  task automatic fall_count;
    @(posedge clk_in);
    cnt_lvl <= 1'b0;
    repeat (5) @(posedge clk_in);
    cnt_lvl <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask : fall_count

  task automatic set_trig(input logic v);
    @(posedge clk_in);
    trig_lvl <= v;
    repeat (6) @(posedge clk_in);
  endtask : set_trig

  task automatic fall_trig;
    set_trig(1'b0);
    set_trig(1'b1);
  endtask : fall_trig
endmodule : tmc_pin_model
